/* File: src/tws_consts.svh */
// constants of the two-wire slave link and its bus master
// assumes inclusion by bare name from the slave and master design files
// What this block does
// - pointer byte follows write address; device loads it
// - master sends pointer in every write
// - reads use last written pointer, kept
// - address plus pointer only just sets pointer
// - register words move high byte first
// - device acks address, pointer, each data byte
// - early end after first byte writes high only
// - read sends high then low byte
// - nack, start or stop ends read; release
// - code 00001xxx not acked, filters go fast
// - high-speed kept over repeated starts until stop
// - master clock 400 kHz, 3 MHz in high-speed
// - line low 22 ms resets interface
// - master clock never below 1 kHz
// - start and stop defined by data under clock
// - no byte count limit per transfer; master sends at most three data bytes (the third from past seq_r) and reads at most three (2-bit cmd_len)
// - receiver holds data low on ninth pulse
// - lines released unless acking or sending
// - address 1001 plus pins latched at start
// - three pointer bits select register
// - bits move most significant first
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
// ----------------------------------------
// addresses and codes
// ----------------------------------------
`define TWS_ADDR_HI 4'h9
`define TWS_HS_CODE 5'h01
`define TWS_PTR_W 3
// ----------------------------------------
// timing
// ----------------------------------------
`define TWS_SYS_MHZ 250
`define TWS_LINK_PERIOD_NS 15
`define TWS_TIMEOUT_MS 22
`define TWS_TO_CYC ((`TWS_TIMEOUT_MS * 1000000) / `TWS_LINK_PERIOD_NS)
`define TWS_FAST_KHZ 400
`define TWS_HS_KHZ 3000
`define TWS_Q_FAST ((`TWS_SYS_MHZ * 1000 + 4 * `TWS_FAST_KHZ - 1) / (4 * `TWS_FAST_KHZ))
`define TWS_Q_HS ((`TWS_SYS_MHZ * 1000 + 4 * `TWS_HS_KHZ - 1) / (4 * `TWS_HS_KHZ))
`endif

/* File: src/tws_pkg.sv */
// types shared by both ends of the two-wire link
// assumes nothing beyond a SystemVerilog compiler
package tws_pkg;
  // device link states
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_RX = 3'h1,
    D_ACK = 3'h2,
    D_TX = 3'h3,
    D_MACK = 3'h4,
    D_IGN = 3'h5
  } tws_dst_t;
  // role of the byte being received
  typedef enum logic [1:0] {
    R_ADDR = 2'h0,
    R_PTR = 2'h1,
    R_DATA = 2'h2
  } tws_role_t;
  // master sequencer states
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BIT = 2'h2,
    H_STOP = 2'h3
  } tws_hst_t;
  typedef logic [15:0] tws_word_t;
endpackage : tws_pkg

/* File: src/tws_if.sv */
// open-drain two-wire bus joining master and slave
// assumes each party drives its enables low to pull a line
`timescale 1ns/10ps
`default_nettype none
interface tws_if;
  logic scl_o_h;
  logic scl_oe_n_h;
  logic sda_o_h;
  logic sda_oe_n_h;
  logic sda_o_d;
  logic sda_oe_n_d;
  logic scl;
  logic sda;
  // data is the wired-and of both parties, clock driven by the host alone; pulled up when released
  assign scl = scl_oe_n_h | scl_o_h;
  assign sda = (sda_oe_n_h | sda_o_h) & (sda_oe_n_d | sda_o_d);
  modport dev (input scl, input sda, output sda_o_d, output sda_oe_n_d);
  modport host (input scl, input sda, output scl_o_h, output scl_oe_n_h, output sda_o_h,
                output sda_oe_n_h);
endinterface : tws_if
`default_nettype wire

/* File: src/tws_dev.sv */
// slave end: pointer, register write and read over the two-wire bus
// assumes clk_link faster than 8x scl; register file lives on clk_sys side
`timescale 1ns/10ps
`default_nettype none
`include "tws_consts.svh"
module tws_dev #(
  parameter int TO_CYC = `TWS_TO_CYC
) (
  input wire logic clk_sys,
  input wire logic clk_link,
  input wire logic rst,
  tws_if.dev bus,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  output logic wr_stb,
  output logic [`TWS_PTR_W-1:0] wr_sel,
  output tws_pkg::tws_word_t wr_data,
  output logic wr_hi_only,
  output logic [`TWS_PTR_W-1:0] rd_sel,
  input wire tws_pkg::tws_word_t rd_data,
  output logic hs_mode
);
  import tws_pkg::*;

  // ----------------------------------------
  // link side: line sampling
  // ----------------------------------------
  logic [3:0] scl_s_r;
  logic [3:0] sda_s_r;
  logic [2:0] asel_s1_r;
  logic [2:0] asel_s2_r;
  logic [2:0] asel_s3_r;
  logic [2:0] asel_q_r;
  logic scl_f_r;
  logic sda_f_r;
  logic scl_p_r;
  logic sda_p_r;
  logic hs_r;

  // stage 0 feeds only stage 1; addr pins share the same depth
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      scl_s_r <= 4'hF;
      sda_s_r <= 4'hF;
      asel_s1_r <= 3'h0;
      asel_s2_r <= 3'h0;
      asel_s3_r <= 3'h0;
      asel_q_r <= 3'h0;
    end else begin
      scl_s_r <= {scl_s_r[2:0], bus.scl};
      sda_s_r <= {sda_s_r[2:0], bus.sda};
      asel_s1_r <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
      asel_s2_r <= asel_s1_r;
      asel_s3_r <= asel_s2_r;
      if (asel_s2_r == asel_s3_r) asel_q_r <= asel_s3_r; // pins count once two stages agree
    end
  end

  // fast mode needs three agreeing samples, high-speed two: shorter spike reject
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      if (scl_s_r[1] == scl_s_r[2] && (hs_r || scl_s_r[2] == scl_s_r[3])) begin
        scl_f_r <= scl_s_r[2];
      end
      if (sda_s_r[1] == sda_s_r[2] && (hs_r || sda_s_r[2] == sda_s_r[3])) begin
        sda_f_r <= sda_s_r[2];
      end
      scl_p_r <= scl_f_r;
      sda_p_r <= sda_f_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  // conditions only count while the clock stays high
  assign scl_rise = scl_f_r & ~scl_p_r;
  assign scl_fall = ~scl_f_r & scl_p_r;
  assign start_ev = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
  assign stop_ev = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;

  // ----------------------------------------
  // link side: stuck-bus timeout
  // ----------------------------------------
  logic busy_r;
  logic [20:0] to_cnt_r;
  logic to_hit;
  assign to_hit = busy_r && (to_cnt_r == 21'(TO_CYC - 1));

  // counts only while a line is low inside a transfer
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      to_cnt_r <= 21'h000000;
    end else begin
      if (start_ev) busy_r <= 1'b1;
      else if (stop_ev || to_hit) busy_r <= 1'b0;
      if (!busy_r || (scl_f_r && sda_f_r) || to_hit) to_cnt_r <= 21'h000000;
      else to_cnt_r <= to_cnt_r + 21'h000001;
    end
  end

  // ----------------------------------------
  // link side: byte engine
  // ----------------------------------------
  tws_dst_t st_r;
  tws_role_t role_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] hi_r;
  logic [2:0] my_addr_r;
  logic [`TWS_PTR_W-1:0] ptr_r;
  logic rw_r;
  logic lo_next_r;
  logic mack_r;
  logic oe_n_r;
  logic wr_tgl_r;
  logic rd_req_r;
  tws_word_t wdat_r;
  logic whi_r;
  tws_word_t rd_word_r;

  // high or low half of the held read word
  function automatic logic [7:0] half(input tws_word_t w, input logic lo);
    half = lo ? w[7:0] : w[15:8];
  endfunction : half

  // stop and timeout outrank start, start outranks the byte work
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      st_r <= D_IDLE;
      role_r <= R_ADDR;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      hi_r <= 8'h00;
      my_addr_r <= 3'h0;
      ptr_r <= 3'h0;
      rw_r <= 1'b0;
      lo_next_r <= 1'b0;
      mack_r <= 1'b0;
      oe_n_r <= 1'b1;
      wr_tgl_r <= 1'b0;
      rd_req_r <= 1'b0;
      wdat_r <= 16'h0000;
      whi_r <= 1'b0;
      hs_r <= 1'b0;
    end else if (stop_ev || to_hit) begin
      st_r <= D_IDLE;
      oe_n_r <= 1'b1;
      hs_r <= 1'b0;
    end else if (start_ev) begin
      st_r <= D_RX; // repeated start keeps hs_r
      role_r <= R_ADDR;
      cnt_r <= 4'h0;
      oe_n_r <= 1'b1;
      my_addr_r <= asel_q_r;
    end else begin
      case (st_r)
        D_RX: begin
          if (scl_rise && cnt_r != 4'h8) begin
            sh_r <= {sh_r[6:0], sda_f_r};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            case (role_r)
              R_ADDR: begin
                if (sh_r[7:3] == `TWS_HS_CODE) begin
                  hs_r <= 1'b1; // no ack
                  st_r <= D_IGN;
                end else if (sh_r[7:1] == {`TWS_ADDR_HI, my_addr_r}) begin
                  rw_r <= sh_r[0];
                  oe_n_r <= 1'b0;
                  st_r <= D_ACK;
                  if (sh_r[0]) rd_req_r <= ~rd_req_r; // fetch word of ptr_r
                end else begin
                  st_r <= D_IGN;
                end
              end
              R_PTR: begin
                ptr_r <= sh_r[`TWS_PTR_W-1:0];
                lo_next_r <= 1'b0;
                oe_n_r <= 1'b0;
                st_r <= D_ACK;
              end
              default: begin
                // each byte is posted at once, so an early end leaves the high only
                if (!lo_next_r) begin
                  hi_r <= sh_r;
                  wdat_r <= {sh_r, 8'h00};
                  whi_r <= 1'b1;
                end else begin
                  wdat_r <= {hi_r, sh_r};
                  whi_r <= 1'b0;
                end
                lo_next_r <= ~lo_next_r; // pairs repeat without limit
                wr_tgl_r <= ~wr_tgl_r;
                oe_n_r <= 1'b0;
                st_r <= D_ACK;
              end
            endcase
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            if (role_r == R_ADDR && rw_r) begin
              sh_r <= half(rd_word_r, 1'b0);
              oe_n_r <= rd_word_r[15];
              lo_next_r <= 1'b1;
              st_r <= D_TX;
            end else begin
              oe_n_r <= 1'b1;
              role_r <= (role_r == R_ADDR) ? R_PTR : R_DATA;
              st_r <= D_RX;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h7) begin
              oe_n_r <= 1'b1; // master's ack slot
              mack_r <= 1'b0;
              st_r <= D_MACK;
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              oe_n_r <= sh_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        D_MACK: begin
          if (scl_rise) begin
            if (sda_f_r) st_r <= D_IGN;
            else mack_r <= 1'b1;
          end else if (scl_fall && mack_r) begin
            sh_r <= half(rd_word_r, lo_next_r);
            oe_n_r <= lo_next_r ? rd_word_r[7] : rd_word_r[15];
            lo_next_r <= ~lo_next_r;
            cnt_r <= 4'h0;
            st_r <= D_TX;
          end
        end
        D_IDLE, D_IGN: begin
          oe_n_r <= 1'b1;
        end
        default: begin
          st_r <= D_IDLE;
        end
      endcase
    end
  end

  assign bus.sda_o_d = 1'b0;
  assign bus.sda_oe_n_d = oe_n_r;

  // ----------------------------------------
  // crossing: write toggle, read request and answer
  // ----------------------------------------
  logic [2:0] wr_s_r;
  logic [2:0] rq_s_r;
  logic [2:0] hs_s_r;
  logic rd_pend_r;
  logic rd_ack_r;
  tws_word_t rd_hold_r;

  // held link words are stable for many sys cycles after a toggle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_s_r <= 3'h0;
      rq_s_r <= 3'h0;
      hs_s_r <= 3'h0;
      wr_stb <= 1'b0;
      wr_sel <= 3'h0;
      wr_data <= 16'h0000;
      wr_hi_only <= 1'b0;
      rd_sel <= 3'h0;
      rd_pend_r <= 1'b0;
      rd_ack_r <= 1'b0;
      rd_hold_r <= 16'h0000;
      hs_mode <= 1'b0;
    end else begin
      wr_s_r <= {wr_s_r[1:0], wr_tgl_r};
      rq_s_r <= {rq_s_r[1:0], rd_req_r};
      hs_s_r <= {hs_s_r[1:0], hs_r};
      if (hs_s_r[1] == hs_s_r[2]) hs_mode <= hs_s_r[2];
      wr_stb <= wr_s_r[1] ^ wr_s_r[2];
      if (wr_s_r[1] ^ wr_s_r[2]) begin
        wr_sel <= ptr_r;
        wr_data <= wdat_r;
        wr_hi_only <= whi_r;
      end
      rd_pend_r <= rq_s_r[1] ^ rq_s_r[2];
      if (rq_s_r[1] ^ rq_s_r[2]) rd_sel <= ptr_r;
      if (rd_pend_r) begin
        rd_hold_r <= rd_data;
        rd_ack_r <= ~rd_ack_r;
      end
    end
  end

  logic [2:0] ak_s_r;
  // answer arrives long before the first data bit is due
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      ak_s_r <= 3'h0;
      rd_word_r <= 16'h0000;
    end else begin
      ak_s_r <= {ak_s_r[1:0], rd_ack_r};
      if (ak_s_r[1] ^ ak_s_r[2]) rd_word_r <= rd_hold_r;
    end
  end
endmodule : tws_dev
`default_nettype wire

/* File: src/tws_host.sv */
// master end: drives the bus clock by division and runs whole transfers
// assumes no clock stretching by the slave
`timescale 1ns/10ps
`default_nettype none
`include "tws_consts.svh"
module tws_host #(
  parameter int Q_FAST = `TWS_Q_FAST,
  parameter int Q_HS = `TWS_Q_HS
) (
  input wire logic clk_sys,
  input wire logic rst,
  tws_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_hs,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_ptr,
  input wire logic [1:0] cmd_len,
  input wire tws_pkg::tws_word_t cmd_wdata,
  output tws_pkg::tws_word_t rdata,
  output logic done,
  output logic nack
);
  import tws_pkg::*;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  tws_hst_t st_r;
  logic [7:0] q_r;
  logic [1:0] ph_r;
  logic [3:0] bitn_r;
  logic [7:0] sh_r;
  logic [7:0] seq_r [0:4];
  logic [2:0] idx_r;
  logic [2:0] last_r;
  logic [1:0] rx_left_r;
  logic rx_r;
  logic ackb_r;
  logic hs_r;
  logic scl_oe_n_r;
  logic sda_oe_n_r;
  logic tick;
  // quarter bit period; high-speed rate only after the code
  assign tick = (q_r == (hs_r ? 8'(Q_HS - 1) : 8'(Q_FAST - 1)));

  logic [2:0] sda_s_r;
  logic sda_q_r;
  // data line is driven from the slave's clock: three stages before use
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_s_r <= 3'h7;
      sda_q_r <= 1'b1;
    end else begin
      sda_s_r <= {sda_s_r[1:0], bus.sda};
      if (sda_s_r[1] == sda_s_r[2]) sda_q_r <= sda_s_r[2];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) q_r <= 8'h00;
    else if (tick || st_r == H_IDLE) q_r <= 8'h00;
    else q_r <= q_r + 8'h01;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= H_IDLE;
      ph_r <= 2'h0;
      bitn_r <= 4'h0;
      sh_r <= 8'h00;
      for (int i = 0; i < 5; i++) seq_r[i] <= 8'h00;
      idx_r <= 3'h0;
      last_r <= 3'h0;
      rx_left_r <= 2'h0;
      rx_r <= 1'b0;
      ackb_r <= 1'b0;
      hs_r <= 1'b0;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      cmd_ready <= 1'b0;
      rdata <= 16'h0000;
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_r)
        H_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            seq_r[0] <= {`TWS_HS_CODE, 3'h0};
            seq_r[1] <= {cmd_addr, cmd_read};
            seq_r[2] <= cmd_ptr;
            seq_r[3] <= cmd_wdata[15:8];
            seq_r[4] <= cmd_wdata[7:0];
            idx_r <= cmd_hs ? 3'h0 : 3'h1;
            last_r <= cmd_read ? 3'h1 : 3'h2 + {1'b0, cmd_len};
            rx_left_r <= cmd_read ? cmd_len : 2'h0;
            rdata <= 16'h0000;
            nack <= 1'b0;
            ph_r <= 2'h0;
            st_r <= H_START;
          end
        end
        H_START: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_oe_n_r <= 1'b1;
              2'h1: scl_oe_n_r <= 1'b1;
              2'h2: sda_oe_n_r <= 1'b0; // data falls under high clock
              default: begin
                scl_oe_n_r <= 1'b0;
                sh_r <= seq_r[idx_r];
                rx_r <= 1'b0;
                bitn_r <= 4'h0;
                st_r <= H_BIT;
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: begin
                if (bitn_r != 4'h8) sda_oe_n_r <= rx_r ? 1'b1 : sh_r[7];
                else sda_oe_n_r <= rx_r ? (rx_left_r == 2'h1) : 1'b1;
              end
              2'h1: scl_oe_n_r <= 1'b1;
              2'h2: begin
                if (bitn_r != 4'h8) sh_r <= {sh_r[6:0], rx_r ? sda_q_r : 1'b0};
                else ackb_r <= sda_q_r;
              end
              default: begin
                scl_oe_n_r <= 1'b0;
                bitn_r <= bitn_r + 4'h1;
                if (bitn_r == 4'h8) begin
                  bitn_r <= 4'h0;
                  if (rx_r) begin
                    rdata <= {rdata[7:0], sh_r}; // high byte lands first
                    rx_left_r <= rx_left_r - 2'h1;
                    if (rx_left_r == 2'h1) st_r <= H_STOP;
                  end else if (ackb_r) begin
                    if (idx_r == 3'h0) begin
                      hs_r <= 1'b1; // repeated start at high rate
                      idx_r <= 3'h1;
                      st_r <= H_START;
                    end else begin
                      nack <= 1'b1;
                      st_r <= H_STOP;
                    end
                  end else if (idx_r == last_r) begin
                    if (rx_left_r != 2'h0) rx_r <= 1'b1;
                    else st_r <= H_STOP; // pointer-only write is legal
                  end else begin
                    idx_r <= idx_r + 3'h1;
                    sh_r <= seq_r[idx_r + 3'h1];
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_oe_n_r <= 1'b0;
              2'h1: scl_oe_n_r <= 1'b1;
              2'h2: sda_oe_n_r <= 1'b1; // data rises under high clock
              default: begin
                hs_r <= 1'b0;
                done <= 1'b1;
                st_r <= H_IDLE;
              end
            endcase
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign bus.scl_o_h = 1'b0;
  assign bus.scl_oe_n_h = scl_oe_n_r;
  assign bus.sda_o_h = 1'b0;
  assign bus.sda_oe_n_h = sda_oe_n_r;
endmodule : tws_host
`default_nettype wire

/* File: bench/tws_link_props.sv */
// bus-level assertions for the two-wire link between host and slave
// assumes raw wired-and levels and the slave data enable, link clock domain
`timescale 1ns/10ps
`default_nettype none
module tws_link_props (
  input wire logic clk_link,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_n_d
);
  // ----------------------------------------
  // framing helpers
  // ----------------------------------------
  logic scl_r, sda_r, busy_r, first_r, wr_r, rd_r, nk_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic rise, ninth, start, stop;
  assign rise = scl & ~scl_r;
  assign ninth = rise & (cnt_r == 4'h8);
  assign start = scl & scl_r & sda_r & ~sda;
  assign stop = scl & scl_r & ~sda_r & sda;
  default clocking cb @(posedge clk_link); endclocking
  default disable iff (rst);
  // previous levels and busy span, raw levels so no filter delay here
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      if (start) busy_r <= 1'b1;
      else if (stop) busy_r <= 1'b0;
    end
  end
  // bit count, shifted byte and kind of transfer
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      {first_r, wr_r, rd_r, nk_r} <= 4'h0;
    end else if (start) begin
      cnt_r <= 4'h0;
      {first_r, wr_r, rd_r, nk_r} <= 4'h8;
    end else if (ninth) begin
      cnt_r <= 4'h0;
      first_r <= 1'b0;
      if (first_r) begin
        wr_r <= ~sh_r[0] & ~sda & (sh_r[7:3] != 5'h01);
        rd_r <= sh_r[0] & ~sda;
      end
      if (rd_r & ~first_r & sda) nk_r <= 1'b1;
    end else if (rise) begin
      cnt_r <= cnt_r + 4'h1;
      sh_r <= {sh_r[6:0], sda};
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_idle_released: assert property (!busy_r |-> sda_oe_n_d)
    else $error("slave drives an idle bus");
  a_change_scl_low: assert property ($changed(sda_oe_n_d) |-> !scl && !$past(scl, 2))
    else $error("slave data moved near a high clock");
  a_pull_before_rise: assert property ($fell(sda_oe_n_d) |-> !scl ##[1:40] scl)
    else $error("slave pull not set up before clock rise");
  a_pull_bounded: assert property ($fell(sda_oe_n_d) |-> ##[1:250] sda_oe_n_d)
    else $error("slave holds data low too long");
  a_hs_code_nack: assert property (ninth && first_r && sh_r[7:3] == 5'h01 |-> sda_oe_n_d)
    else $error("speed code acknowledged");
  a_write_byte_ack: assert property (ninth && wr_r && !first_r |-> !sda_oe_n_d)
    else $error("written byte not acknowledged");
  a_read_ack_slot: assert property (ninth && rd_r && !first_r |-> sda_oe_n_d)
    else $error("slave drives the master ack slot");
  a_nack_release: assert property (nk_r |-> sda_oe_n_d)
    else $error("slave drives after master nack");
  c_hs_code: cover property (ninth && first_r && sh_r[7:3] == 5'h01);
  c_write_data: cover property (ninth && wr_r && !first_r);
  c_read_nack: cover property ($rose(nk_r));
endmodule : tws_link_props
`default_nettype wire

/* File: bench/tb_top.sv */
// bench: host and slave on one link, second slave stalled for the timeout
// assumes design files compiled first; counts shortened by parameters
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tws_pkg::*;
  localparam int QF = 20;
  localparam int QH = 14;
  localparam int TO = 2000;
  logic clk_sys, clk_link, rst, cmd_valid, cmd_ready, cmd_read, cmd_hs, done, nack;
  logic wr_stb, wr_hi_only, hs_mode, saw_hs;
  logic [2:0] wr_sel, rd_sel, pins;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_ptr, cur_ptr;
  logic [1:0] cmd_len, ln;
  logic [31:0] seed;
  tws_word_t cmd_wdata, rdata, wr_data, rd_data;
  tws_word_t regs [8];
  tws_word_t expv [8];
  int num_errors, checked;
  tws_if bus ();
  tws_if bus2 ();
  tws_dev #(.TO_CYC(TO)) tws_dev_inst (.clk_sys(clk_sys), .clk_link(clk_link), .rst(rst),
    .bus(bus.dev), .addr_select_bit0(pins[0]), .addr_select_bit1(pins[1]),
    .addr_select_bit2(pins[2]), .wr_stb(wr_stb), .wr_sel(wr_sel), .wr_data(wr_data),
    .wr_hi_only(wr_hi_only), .rd_sel(rd_sel), .rd_data(rd_data), .hs_mode(hs_mode));
  tws_dev #(.TO_CYC(TO)) tws_dev_inst2 (.clk_sys(clk_sys), .clk_link(clk_link), .rst(rst),
    .bus(bus2.dev), .addr_select_bit0(pins[0]), .addr_select_bit1(pins[1]),
    .addr_select_bit2(pins[2]), .wr_stb(), .wr_sel(), .wr_data(), .wr_hi_only(),
    .rd_sel(), .rd_data(rd_data), .hs_mode());
  tws_host #(.Q_FAST(QF), .Q_HS(QH)) tws_host_inst (.clk_sys(clk_sys), .rst(rst),
    .bus(bus.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_hs(cmd_hs), .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr), .cmd_len(cmd_len),
    .cmd_wdata(cmd_wdata), .rdata(rdata), .done(done), .nack(nack));
  tws_link_props tws_link_props_inst (.clk_link(clk_link), .rst(rst), .scl(bus.scl),
    .sda(bus.sda), .sda_oe_n_d(bus.sda_oe_n_d));
  // ----------------------------------------
  // clocks, register file, helpers
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // link clock offset so its edges never line up with the system clock
  initial begin
    clk_link = 1'b0;
    #3.3;
    forever #7.5 clk_link = ~clk_link;
  end
  // register file behind the slave, lookup combinational on the select
  assign rd_data = regs[rd_sel];
  always @(posedge clk_sys) begin
    if (wr_stb === 1'b1 && wr_hi_only === 1'b1) regs[wr_sel][15:8] <= wr_data[15:8];
    else if (wr_stb === 1'b1) regs[wr_sel] <= wr_data;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // a one-byte read returns only the high byte
  function automatic tws_word_t exp_rd(input logic [1:0] len, input tws_word_t v);
    return (len == 2'h1) ? {8'h00, v[15:8]} : v;
  endfunction : exp_rd
  task automatic chk(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // one whole host command, then its expected effects
  task automatic xfer(input logic rd, input logic hs, input logic [6:0] a, input logic [7:0] p,
                      input logic [1:0] len, input tws_word_t wd);
    int n;
    logic m;
    logic ok;
    @(posedge clk_sys);
    #1;
    {cmd_valid, cmd_read, cmd_hs, cmd_addr, cmd_ptr, cmd_len, cmd_wdata} = {1'b1, rd, hs, a, p,
      len, wd};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 5000);
    #1;
    cmd_valid = 1'b0;
    saw_hs = 1'b0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
      saw_hs |= (hs_mode === 1'b1);
    end while (done !== 1'b1 && n < 30000);
    chk(n < 30000, "no done");
    m = (a == {4'h9, pins});
    chk(nack === !m, "address ack");
    chk(saw_hs === hs, "speed entry");
    repeat (20) @(posedge clk_sys);
    chk(hs_mode === 1'b0, "speed after stop");
    if (m && rd) chk(rdata === exp_rd(len, expv[cur_ptr[2:0]]), "read word");
    if (m && !rd) begin
      cur_ptr = p;
      if (len == 2'h1) expv[p[2:0]][15:8] = wd[15:8];
      if (len == 2'h2) expv[p[2:0]] = wd;
    end
    ok = 1'b1;
    foreach (expv[i]) ok &= (regs[i] === expv[i]);
    chk(ok, "register contents");
  endtask : xfer
  // second link, bench plays the master
  task automatic drv2(input logic c, input logic d, input int t);
    bus2.scl_oe_n_h = c;
    bus2.sda_oe_n_h = d;
    #(t);
  endtask : drv2
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {cmd_valid, cmd_read, cmd_hs, cmd_addr, cmd_ptr, cmd_len, cmd_wdata} = '0;
    {bus2.scl_o_h, bus2.sda_o_h, bus2.scl_oe_n_h, bus2.sda_oe_n_h} = 4'h3;
    pins = 3'h5;
    cur_ptr = 8'h00;
    seed = 32'h1AE58392;
    foreach (regs[i]) regs[i] = 16'(16'h1111 * i + 16'h0F0F);
    expv = regs;
    rst = 1'b1;
    repeat (6) @(posedge clk_link);
    #1;
    rst = 1'b0;
    repeat (10) @(posedge clk_link);
    xfer(1'b0, 1'b0, 7'h4D, 8'hF9, 2'h2, 16'hA55A);
    xfer(1'b0, 1'b0, 7'h4D, 8'h03, 2'h0, 16'h0000);
    xfer(1'b1, 1'b0, 7'h4D, 8'h03, 2'h2, 16'h0000);
    xfer(1'b1, 1'b0, 7'h4D, 8'h03, 2'h2, 16'h0000);
    xfer(1'b0, 1'b0, 7'h4D, 8'h02, 2'h1, 16'h3C00);
    xfer(1'b1, 1'b0, 7'h4D, 8'h02, 2'h1, 16'h0000);
    xfer(1'b0, 1'b0, 7'h4C, 8'h01, 2'h2, 16'hFFFF);
    xfer(1'b0, 1'b1, 7'h4D, 8'h01, 2'h2, 16'h0001);
    xfer(1'b1, 1'b1, 7'h4D, 8'h01, 2'h2, 16'h0000);
    $display("test corner cases done");
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      pins = seed[2:0];
      seed = xs(seed);
      ln = (seed[6:5] == 2'h3) ? 2'h2 : seed[6:5];
      if (seed[0] && ln == 2'h0) ln = 2'h1;
      xfer(seed[0], seed[1], {4'h9, pins ^ {2'h0, seed[2] & seed[3]}},
           seed[0] ? cur_ptr : seed[15:8], ln, seed[31:16]);
    end
    $display("test random transfers done");
    @(posedge clk_sys);
    #1;
    drv2(1'b1, 1'b0, 200);
    drv2(1'b0, 1'b0, 200);
    for (int b = 7; b >= 0; b--) begin
      drv2(1'b0, b < 4 && b > 0 ? pins[b-1] : (b == 7 || b == 4), 100);
      drv2(1'b1, bus2.sda_oe_n_h, 300);
      drv2(1'b0, bus2.sda_oe_n_h, 100);
    end
    drv2(1'b0, 1'b1, 300);
    chk(bus2.sda_oe_n_d === 1'b0, "ack before stall");
    drv2(1'b0, 1'b1, TO * 15 + 2000);
    chk(bus2.sda_oe_n_d === 1'b1, "released after stall");
    $display("test bus timeout done");
    print_verdict();
  end
  // nearly twice the expected run length, under 100k system cycles
  initial begin
    #380000;
    num_errors++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
